/* File: pkg/snv_link_if.sv */
// snv_link_if: the spi wires between master end and target end
// assumes the bench resolves the shared pins; no clocking here
`timescale 1ns/1ps
interface snv_link_if;
  logic sel_n;       // chip enable, active low
  logic sck;         // serial clock
  logic mosi;        // serial data in to target
  logic miso_o;      // target data out value
  logic miso_oe;     // target drives data out
  logic pause_n;     // hold, active low
  logic lock_n;      // status write lock, active low
  modport target (input sel_n, sck, mosi, pause_n, lock_n, output miso_o, miso_oe);
  modport master (output sel_n, sck, mosi, pause_n, lock_n, input miso_o, miso_oe);
endinterface

/* File: pkg/snv_pkg.sv */
// snv_pkg: types shared by both ends of the serial nvram link
// assumes snv_regs.svh is on the include path
package snv_pkg;
  `include "snv_regs.svh"
  typedef logic [`SNV_BYTE_W-1:0] snv_byte_t;
  typedef logic [`SNV_ADDR_W-1:0] snv_addr_t;
  typedef enum logic [1:0] {SNV_OP_READ, SNV_OP_WRITE, SNV_OP_CMD} snv_op_t;
endpackage

/* File: pkg/snv_regs.svh */
// snv_regs.svh: constants for the serial nvram spi target front end
// assumes inclusion by the package and both ends; definitions only
`ifndef SNV_REGS_SVH
`define SNV_REGS_SVH
`define SNV_ADDR_W       16
`define SNV_BYTE_W       8
`define SNV_MEM_DEPTH    65536
`define SNV_FIFO_DEPTH   8
`define SNV_CMD_WREN     8'h06
`define SNV_CMD_WRDI     8'h04
`define SNV_CMD_RDSR     8'h05
`define SNV_CMD_WRSR     8'h01
`define SNV_CMD_READ     8'h03
`define SNV_CMD_FSTRD    8'h0b
`define SNV_CMD_WRITE    8'h02
`define SNV_SR_FIXED     8'h40
`define SNV_SR_WMASK     8'h8c
`define SNV_SR_WEL_BIT   1
`define SNV_SR_WPEN_BIT  7
`define SNV_SCK_HALF_NS  60
`define SNV_CLK_NS       10
`define SNV_SCK_HALF_CYC ((`SNV_SCK_HALF_NS + `SNV_CLK_NS - 1) / `SNV_CLK_NS)
`endif

/* File: rtl/snv_fifo.sv */
// snv_fifo: small synchronous fifo, valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module snv_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         clock_i,   // clock
  input  wire logic         rstn_i,    // sync reset
  input  wire logic [W-1:0] in_data_i, // write data
  input  wire logic         in_valid_i,// write valid
  output logic              in_ready_o,// not full
  output logic [W-1:0]      out_data_o,// head data
  output logic              out_valid_o,// not empty
  input  wire logic         out_ready_i // pop
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic push, pop;
  assign in_ready_o  = (cnt_q != (AW+1)'(D));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];
  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;
  always_comb
  begin
    wp_d  = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d  = pop ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = (AW+1)'(cnt_q + push - pop);
  end
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
    if (push)
      mem_q[wp_q] <= in_data_i;
  end
endmodule

/* File: rtl/snv_master.sv */
// snv_master: spi master end; bytes in through a fifo, bytes back out
// assumes one clock; sck made by a divider, mode 0
`timescale 1ns/1ps
`include "snv_regs.svh"
module snv_master
  import snv_pkg::*;
(
  input  wire logic      clock_i,    // system clock
  input  wire logic      rstn_i,     // sync reset, active low
  snv_link_if.master     link,       // spi pins
  input  wire snv_byte_t tx_data_i,  // byte to send
  input  wire logic      tx_valid_i, // byte offered
  input  wire logic      tx_last_i,  // deselect after this byte
  output logic           tx_ready_o, // fifo has room
  output snv_byte_t      rx_data_o,  // byte received
  output logic           rx_valid_o, // one-cycle pulse
  input  wire logic      pause_i,    // request hold
  input  wire logic      lock_i      // assert status lock
);
  typedef enum logic [1:0] {M_IDLE, M_SHIFT, M_GAP} snv_mst_t;
  logic [8:0] f_out;
  logic       f_valid, f_pop;
  snv_fifo #(.W(9), .D(`SNV_FIFO_DEPTH)) u_fifo (
    .clock_i     (clock_i),
    .rstn_i      (rstn_i),
    .in_data_i   ({tx_last_i, tx_data_i}),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .out_data_o  (f_out),
    .out_valid_o (f_valid),
    .out_ready_i (f_pop)
  );
  logic [1:0] s_miso;
  snv_mst_t st_q, st_d;
  logic [7:0] div_q, div_d;
  logic [7:0] sh_q, sh_d, rx_q, rx_d;
  logic [2:0] bit_q, bit_d;
  logic sck_q, sck_d, sel_q, sel_d, last_q, last_d, rxv_q, rxv_d, pause_q, pause_d;
  logic tick, pause_chg;
  assign tick = div_q == 8'(`SNV_SCK_HALF_CYC - 1);
  // hold moves only on a tick that leaves the clock low, never with an edge
  assign pause_chg = tick & ~sck_q & (pause_i != pause_q);
  always_comb
  begin
    st_d = st_q; div_d = tick ? 8'h00 : 8'(div_q + 1'b1); sh_d = sh_q; rx_d = rx_q;
    bit_d = bit_q; sck_d = sck_q; sel_d = sel_q; last_d = last_q; rxv_d = 1'b0;
    pause_d = pause_q; f_pop = 1'b0;
    // pause changes only with the clock low
    if (pause_chg)
      pause_d = pause_i;
    case (st_q)
      M_IDLE:
        if (tick && f_valid && !pause_q && !pause_chg)
        begin
          sel_d = 1'b0; sh_d = f_out[7:0]; last_d = f_out[8]; f_pop = 1'b1;
          bit_d = 3'h0; st_d = M_SHIFT;
        end
      M_SHIFT:
        if (tick && !pause_q && !pause_chg)
        begin
          sck_d = ~sck_q;
          if (!sck_q)
            rx_d = {rx_q[6:0], s_miso[1]};
          else
          begin
            sh_d = {sh_q[6:0], 1'b0};
            bit_d = 3'(bit_q + 1'b1);
            if (bit_q == 3'h7)
            begin
              rxv_d = 1'b1;
              if (last_q)
                st_d = M_GAP;
              else if (f_valid)
              begin
                sh_d = f_out[7:0]; last_d = f_out[8]; f_pop = 1'b1;
              end
              else
                st_d = M_GAP;                      // starved: end frame
            end
          end
        end
      M_GAP:
        if (tick)
        begin
          sel_d = 1'b1; st_d = M_IDLE;
        end
      default: st_d = M_IDLE;
    endcase
  end
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      s_miso <= 2'h0; st_q <= M_IDLE; div_q <= 8'h00; sh_q <= 8'h00; rx_q <= 8'h00;
      bit_q <= 3'h0; sck_q <= 1'b0; sel_q <= 1'b1; last_q <= 1'b0; rxv_q <= 1'b0;
      pause_q <= 1'b0;
    end
    else
    begin
      s_miso <= {s_miso[0], link.miso_o & link.miso_oe};
      st_q <= st_d; div_q <= div_d; sh_q <= sh_d; rx_q <= rx_d; bit_q <= bit_d;
      sck_q <= sck_d; sel_q <= sel_d; last_q <= last_d; rxv_q <= rxv_d; pause_q <= pause_d;
    end
  end
  assign link.sel_n   = sel_q;
  assign link.sck     = sck_q;
  assign link.mosi    = sh_q[7];
  assign link.pause_n = ~pause_q;
  assign link.lock_n  = ~lock_i;
  assign rx_data_o    = rx_q;
  assign rx_valid_o   = rxv_q;
endmodule

/* File: rtl/snv_target.sv */
// snv_target: spi target end of a 64k x 8 serial nvram
// assumes link pins are asynchronous; they pass two flops first
// Function
// - deselected: standby, ignore inputs, output off
// - command only after select falling edge
// - capture on rising, launch on falling
// - any clock rate, clock may stop
// - pause freezes transaction, edges ignored
// - master changes pause only clock low
// - lock pin blocks status writes only; here it blocks them only while status bit 7 (WPEN) is set
// - data in sampled only on rising
// - output driven only during read data
// - 65536 bytes, 16-bit two-byte address
// - byte committed at bus speed, never busy
// - mode from clock idle at select
// - first bit at first rising edge
// - master lowers idle-high clock first
// - first byte command, then address, data
// - one command per select period
// - 8-bit groups, msb first
// - writes disabled after power-up
`timescale 1ns/1ps
`include "snv_regs.svh"
module snv_target
  import snv_pkg::*;
(
  input  wire logic clock_i,       // system clock
  input  wire logic rstn_i,        // sync reset, active low
  snv_link_if.target link,         // spi pins
  output logic      busy_o,        // always low, writes never stall
  output logic      cpol_o         // mode seen at last select: 1 = mode 3
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] s_sel, s_sck, s_mosi, s_pause, s_lock;
  logic sck_prev_q, sel_prev_q;
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      s_sel   <= 2'h3;
      s_sck   <= 2'h0;
      s_mosi  <= 2'h0;
      s_pause <= 2'h3;
      s_lock  <= 2'h3;
      sck_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
    end
    else
    begin
      s_sel   <= {s_sel[0], link.sel_n};
      s_sck   <= {s_sck[0], link.sck};
      s_mosi  <= {s_mosi[0], link.mosi};
      s_pause <= {s_pause[0], link.pause_n};
      s_lock  <= {s_lock[0], link.lock_n};
      sck_prev_q <= s_sck[1];
      sel_prev_q <= s_sel[1];
    end
  end
  logic sel_n, sck, mosi, pause_n, lock_n, rise, fall, sel_fall;
  assign sel_n   = s_sel[1];
  assign sck     = s_sck[1];
  assign mosi    = s_mosi[1];
  assign pause_n = s_pause[1];
  assign lock_n  = s_lock[1];
  // held edges are swallowed, and clock level is tracked anyway
  assign rise     = pause_n & sck & ~sck_prev_q;
  assign fall     = pause_n & ~sck & sck_prev_q;
  assign sel_fall = pause_n & ~sel_n & sel_prev_q;

  // ----------------------------------------------------------------
  // array and state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_SRW, ST_DONE} snv_st_t;
  snv_byte_t mem [`SNV_MEM_DEPTH];
  snv_st_t   st_q, st_d;
  snv_byte_t sh_q, sh_d, cmd_q, cmd_d, out_q, out_d, sr_q, sr_d;
  snv_addr_t addr_q, addr_d;
  logic [2:0] bit_q, bit_d;
  logic       abyte_q, abyte_d, fast_q, fast_d, dummy_q, dummy_d;
  logic       drv_q, drv_d, cpol_q, cpol_d, mem_we;
  snv_byte_t  inbyte;
  logic       bdone, wr_ok, bp_hit;
  assign inbyte = {sh_q[6:0], mosi};
  assign bdone  = rise & (bit_q == 3'h7);
  always_comb
  begin
    case (sr_q[3:2])
      2'h1:    bp_hit = addr_q[15:14] == 2'h3;
      2'h2:    bp_hit = addr_q[15];
      2'h3:    bp_hit = 1'b1;
      default: bp_hit = 1'b0;
    endcase
  end
  assign wr_ok  = sr_q[`SNV_SR_WEL_BIT] & ~bp_hit; // lock pin plays no part
  assign mem_we = (st_q == ST_WDATA) & bdone & wr_ok & ~sel_n;
  assign busy_o = 1'b0;
  assign cpol_o = cpol_q;

  always_comb
  begin
    st_d = st_q; sh_d = sh_q; cmd_d = cmd_q; out_d = out_q; sr_d = sr_q;
    addr_d = addr_q; bit_d = bit_q; abyte_d = abyte_q; fast_d = fast_q;
    dummy_d = dummy_q; drv_d = drv_q; cpol_d = cpol_q;
    if (sel_n)
    begin
      // deselect drops any partial byte and the command
      st_d = ST_IDLE; bit_d = 3'h0; drv_d = 1'b0;
    end
    else if (sel_fall)
    begin
      cpol_d = sck;
      st_d = ST_CMD; bit_d = 3'h0; drv_d = 1'b0;
      dummy_d = 1'b0;
    end
    else if (rise)
    begin
      sh_d  = inbyte;
      bit_d = 3'(bit_q + 1'b1);
      if (bdone)
      begin
        case (st_q)
          ST_CMD:
          begin
            cmd_d = inbyte; abyte_d = 1'b0; fast_d = inbyte == `SNV_CMD_FSTRD;
            case (inbyte)
              `SNV_CMD_WREN: begin sr_d[`SNV_SR_WEL_BIT] = 1'b1; st_d = ST_DONE; end
              `SNV_CMD_WRDI: begin sr_d[`SNV_SR_WEL_BIT] = 1'b0; st_d = ST_DONE; end
              `SNV_CMD_RDSR: begin out_d = sr_q; st_d = ST_RDATA; end
              `SNV_CMD_WRSR: st_d = ST_SRW;
              `SNV_CMD_READ, `SNV_CMD_FSTRD, `SNV_CMD_WRITE: st_d = ST_ADDR;
              default: st_d = ST_DONE;
            endcase
          end
          ST_ADDR:
          begin
            if (!abyte_q)
            begin
              addr_d[15:8] = inbyte; abyte_d = 1'b1;
            end
            else
            begin
              addr_d[7:0] = inbyte;
              dummy_d = fast_q;
              if (cmd_q == `SNV_CMD_WRITE)
                st_d = ST_WDATA;
              else
              begin
                st_d = ST_RDATA; out_d = mem[{addr_q[15:8], inbyte}];
              end
            end
          end
          ST_WDATA:
          begin
            addr_d = 16'(addr_q + 1'b1);
            if (wr_ok == 1'b0)
              st_d = ST_WDATA;
          end
          ST_SRW:
          begin
            if (sr_q[`SNV_SR_WEL_BIT] && !(sr_q[`SNV_SR_WPEN_BIT] && !lock_n))
              sr_d = (inbyte & `SNV_SR_WMASK) | `SNV_SR_FIXED;
            sr_d[`SNV_SR_WEL_BIT] = 1'b0;
            st_d = ST_DONE;
          end
          ST_RDATA:
          begin
            if (dummy_q)
              dummy_d = 1'b0;
            else if (cmd_q != `SNV_CMD_RDSR)
              addr_d = 16'(addr_q + 1'b1);
          end
          default: st_d = ST_DONE;
        endcase
      end
    end
    else if (fall)
    begin
      // each read byte is loaded at its first falling edge, so data out
      // never moves while the clock is high
      if (st_q == ST_RDATA && !dummy_q)
      begin
        drv_d = 1'b1;
        if (bit_q == 3'h0)
          out_d = (cmd_q == `SNV_CMD_RDSR) ? sr_q : mem[addr_q];
        else
          out_d = {out_q[6:0], 1'b0};
      end
    end
    if (st_q == ST_WDATA && sel_n && sel_prev_q == 1'b0)
      sr_d[`SNV_SR_WEL_BIT] = 1'b0;                // write completed clears latch
  end

  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      st_q <= ST_IDLE; sh_q <= 8'h00; cmd_q <= 8'h00; out_q <= 8'h00;
      sr_q <= `SNV_SR_FIXED;
      addr_q <= 16'h0000; bit_q <= 3'h0; abyte_q <= 1'b0; fast_q <= 1'b0;
      dummy_q <= 1'b0; drv_q <= 1'b0; cpol_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d; sh_q <= sh_d; cmd_q <= cmd_d; out_q <= out_d; sr_q <= sr_d;
      addr_q <= addr_d; bit_q <= bit_d; abyte_q <= abyte_d; fast_q <= fast_d;
      dummy_q <= dummy_d; drv_q <= drv_d; cpol_q <= cpol_d;
    end
    if (mem_we)
      mem[addr_q] <= inbyte;
  end
  // output off while deselected or paused
  assign link.miso_o  = out_q[7];
  assign link.miso_oe = drv_q & ~sel_n & pause_n;
endmodule

/* File: test/snv_properties.sv */
// snv_properties: timing relations on the spi wires between both ends
// assumes plain link signals and the system clock domain
`timescale 1ns/1ps
module snv_properties (
  input wire logic clock_i, // system clock
  input wire logic rstn_i,  // sync reset, active low
  input wire logic sel_n,   // chip enable
  input wire logic sck,     // serial clock
  input wire logic mosi,    // data to target
  input wire logic miso_o,  // target data value
  input wire logic miso_oe, // target drives data
  input wire logic pause_n  // hold
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);

  // five cycles leave room for the two input flops
  a_desel_out_off: assert property (sel_n [*5] |-> !miso_oe)
    else $error("data out driven while deselected");
  a_pause_out_off: assert property (!pause_n [*5] |-> !miso_oe)
    else $error("data out driven while paused");
  a_out_launch_low: assert property (miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sck)
    else $error("data out changed while clock high");
  a_in_stable_high: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("data in moved while clock high");
  a_select_clock_low: assert property ($fell(sel_n) |-> !sck)
    else $error("select fell with clock high");
  a_pause_moves_low: assert property ($changed(pause_n) |-> !sck && !$past(sck))
    else $error("hold changed near clock high");
  a_idle_clock_still: assert property (sel_n |-> !sck)
    else $error("clock runs outside a frame");
  a_rise_selected: assert property ($rose(sck) |-> !sel_n)
    else $error("rising clock edge while deselected");
  a_half_period: assert property ($rose(sck) |-> sck [*6])
    else $error("clock high phase too short");
endmodule

/* File: test/test_serial_nvram_spi_target_frontend.sv */
// test_serial_nvram_spi_target_frontend: master end talks to target end
// assumes snv_pkg, snv_link_if, fifo and both ends compiled first
`timescale 1ns/1ps
`include "snv_regs.svh"
module test_serial_nvram_spi_target_frontend
  import snv_pkg::*;
  ;
  logic      clock_i    = 1'b0;
  logic      rstn_i     = 1'b0;
  snv_byte_t tx_data_i  = 8'h00;
  logic      tx_valid_i = 1'b0;
  logic      tx_last_i  = 1'b0;
  logic      pause_i    = 1'b0;
  logic      lock_i     = 1'b0;
  logic      tx_ready_o;
  logic      rx_valid_o;
  logic      busy_o;
  logic      cpol_o;
  snv_byte_t rx_data_o;
  snv_byte_t rx_q[$];
  snv_addr_t a;
  snv_byte_t d;
  int        fails  = 0;
  int        checks = 0;

  snv_link_if link_if ();
  snv_target i_snv_target (.clock_i(clock_i), .rstn_i(rstn_i), .link(link_if), .busy_o(busy_o), .cpol_o(cpol_o));
  snv_master i_snv_master (.clock_i(clock_i), .rstn_i(rstn_i), .link(link_if), .tx_data_i(tx_data_i),
    .tx_valid_i(tx_valid_i), .tx_last_i(tx_last_i), .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .pause_i(pause_i), .lock_i(lock_i));
  snv_properties i_snv_properties (.clock_i(clock_i), .rstn_i(rstn_i), .sel_n(link_if.sel_n),
    .sck(link_if.sck), .mosi(link_if.mosi), .miso_o(link_if.miso_o), .miso_oe(link_if.miso_oe),
    .pause_n(link_if.pause_n));

  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) if (rx_valid_o === 1'b1) rx_q.push_back(rx_data_o);

  task automatic chk(input string what, input snv_byte_t exp, input snv_byte_t got);
    checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // bounded wait for the select line; a hang ends the run
  task automatic wait_sel(input logic lvl, input int bound);
    int n;
    n = 0;
    while (link_if.sel_n !== lvl && n < bound)
    begin
      @(posedge clock_i);
      n++;
    end
    if (n >= bound)
    begin
      fails++;
      $display("[FAIL] sel_n expected %b seen %b", lvl, link_if.sel_n);
      finish_test();
    end
  endtask

  // frames stay under the fifo depth, so one byte a cycle is accepted
  task automatic frame(input snv_byte_t b[$]);
    rx_q.delete();
    foreach (b[i])
    begin
      @(posedge clock_i);
      tx_data_i  <= b[i];
      tx_valid_i <= 1'b1;
      tx_last_i  <= (i == b.size() - 1);
    end
    @(posedge clock_i);
    tx_valid_i <= 1'b0;
    tx_last_i  <= 1'b0;
    wait_sel(1'b0, 200);
    wait_sel(1'b1, 8000);
    repeat (10) @(posedge clock_i);
    chk("busy and mode", 8'h00, {6'h00, busy_o, cpol_o});
    chk("fifo ready", 8'h01, {7'h00, tx_ready_o});
  endtask

  task automatic wr(input snv_addr_t wa, input snv_byte_t wd);
    frame({`SNV_CMD_WREN});
    frame({`SNV_CMD_WRITE, wa[15:8], wa[7:0], wd});
  endtask

  task automatic rd(input snv_addr_t ra, input snv_byte_t exp);
    frame({`SNV_CMD_READ, ra[15:8], ra[7:0], 8'h00});
    chk("read data", exp, rx_q[3]);
  endtask

  task automatic sr(input snv_byte_t exp, input snv_byte_t mask);
    frame({`SNV_CMD_RDSR, 8'h00});
    chk("status", exp, rx_q[1] & mask);
  endtask

  initial
  begin
    void'($urandom(32'h0381a739));
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'b1;
    sr(`SNV_SR_FIXED, 8'hff);
    wr(16'h1234, 8'h5a);
    frame({`SNV_CMD_WRITE, 8'h12, 8'h34, 8'ha5});
    rd(16'h1234, 8'h5a);
    $display("test write enable done");
    frame({`SNV_CMD_WREN});
    sr(`SNV_SR_FIXED | 8'h02, 8'hff);
    frame({`SNV_CMD_WRDI});
    sr(`SNV_SR_FIXED, 8'hff);
    $display("test latch commands done");
    for (int i = 0; i < 6; i++)
    begin
      a = (i == 0) ? 16'h0000 : (i == 1) ? 16'hffff : snv_addr_t'($urandom);
      d = snv_byte_t'($urandom);
      lock_i <= 1'($urandom);
      wr(a, d);
      rd(a, d);
      frame({`SNV_CMD_FSTRD, a[15:8], a[7:0], 8'h00, 8'h00});
      chk("fast read data", d, rx_q[4]);
    end
    $display("test random access done");
    lock_i <= 1'b0;
    frame({`SNV_CMD_WREN});
    frame({`SNV_CMD_WRSR, 8'h80});
    sr(8'hc0, 8'hfd);
    lock_i <= 1'b1;
    frame({`SNV_CMD_WREN});
    frame({`SNV_CMD_WRSR, 8'h8c});
    sr(8'hc0, 8'hfd);
    wr(16'h2222, 8'h3c);
    rd(16'h2222, 8'h3c);
    lock_i <= 1'b0;
    frame({`SNV_CMD_WREN});
    frame({`SNV_CMD_WRSR, 8'h00});
    $display("test status lock done");
    // hold lands in the data byte of the read
    fork
      rd(16'h2222, 8'h3c);
      begin
        repeat (330) @(posedge clock_i);
        pause_i <= 1'b1;
        repeat (300) @(posedge clock_i);
        pause_i <= 1'b0;
      end
    join
    $display("test pause done");
    finish_test();
  end
endmodule
